/* rtl/sarcs_top.sv */
// Conversion sequencer and amplifier control
`timescale 1ns/1ps
`default_nettype none

`include "sarcs_cfg.svh"

module sarcs_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  // Start sources and standby
  input  wire logic        tmr2_ovf,
  input  wire logic        tmr3_ovf,
  input  wire logic        ext_convert_start_pin,
  input  wire logic        chip_standby,
  // Analog front end
  input  wire logic [9:0]  sar_result,
  output logic             hv_amp_enable,
  output logic      [3:0]  hv_amp_gain_select,
  output logic             hv_ref_to_neg,
  output logic             conv_enable,
  output logic             track_en,
  output logic             convert_en,
  output logic             conv_irq
);

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  logic [7:0]               hv_amp_q;
  logic [7:0]               ctrl_q;
  logic [7:0]               cfg_q;
  logic [7:0]               mux_q;
  logic [7:0]               res_hi_q;
  logic [7:0]               res_lo_q;
  logic [7:0]               rdata_q;
  logic                     busy_q;
  logic                     done_q;
  logic                     pin_s1_q;
  logic                     pin_s2_q;
  logic                     pin_s3_q;
  logic                     sby_s1_q;
  logic                     sby_s2_q;
  logic [3:0]               clk_cnt_q;
  logic [3:0]               clk_cnt_d;
  logic [15:0]              rate_cnt_q;
  logic                     irq_q;
  logic                     track_q;
  logic                     convert_q;
  sarcs_pkg::sarcs_state_t  state_q;
  sarcs_pkg::sarcs_state_t  state_d;

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  wire        sel_hv    = (addr == `SARCS_OFF_HV_AMP);
  wire        sel_ctl   = (addr == `SARCS_OFF_CONV_CTRL);
  wire        sel_cfg   = (addr == `SARCS_OFF_CONV_CFG);
  wire        sel_hi    = (addr == `SARCS_OFF_RES_HI);
  wire        sel_lo    = (addr == `SARCS_OFF_RES_LO);
  wire        sel_mux   = (addr == `SARCS_OFF_MUX_CFG);
  wire        wr_ctl    = wr_en && sel_ctl;
  wire        adc_on    = ctrl_q[`SARCS_CTL_EN_BIT];
  wire        tm_lp     = ctrl_q[`SARCS_CTL_TM_BIT];
  wire        lj        = ctrl_q[`SARCS_CTL_LJ_BIT];
  wire [1:0]  cm        = ctrl_q[`SARCS_CTL_CM_HI:`SARCS_CTL_CM_LO];
  wire [4:0]  div       = cfg_q[`SARCS_CFG_DIV_HI:`SARCS_CFG_DIV_LO];
  wire        pin_rise  = pin_s2_q && !pin_s3_q;
  wire        pin_low   = !pin_s2_q;
  wire        soft_go   = wr_ctl && wdata[`SARCS_CTL_BUSY_BIT];

  // -------------------------------------------------------------------------
  // Start selection
  // -------------------------------------------------------------------------
  // Start source select
  wire        start_raw = (cm == sarcs_pkg::SARCS_SRC_SOFT) ? soft_go :
                          (cm == sarcs_pkg::SARCS_SRC_TMR3) ? tmr3_ovf :
                          (cm == sarcs_pkg::SARCS_SRC_PIN)  ? pin_rise :
                                                              tmr2_ovf;
  // Rate limit to 100 ksps
  wire        rate_ok   = (rate_cnt_q == 16'h0000);
  // Starts while busy are dropped
  wire        start     = adc_on && start_raw && !busy_q && rate_ok;

  // -------------------------------------------------------------------------
  // Conversion clock
  // -------------------------------------------------------------------------
  wire        sar_tick;
  wire        div_run   = (state_q != sarcs_pkg::SARCS_IDLE);

  // Period is system period times divider plus one
  sarcs_clk_div u_div (
    .clock (clock),
    .rst_n (rst_n),
    .run   (div_run),
    .div   (div),
    .tick  (sar_tick)
  );

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  wire        pin_lp    = tm_lp && (cm == sarcs_pkg::SARCS_SRC_PIN);
  wire        track_end = sar_tick && (clk_cnt_q == `SARCS_TRACK_CLKS - 4'h1);
  wire        conv_end  = sar_tick && (clk_cnt_q == `SARCS_CONV_CLKS - 4'h1);
  wire        finish    = (state_q == sarcs_pkg::SARCS_CONVERT) && conv_end;

  always_comb begin
    state_d   = state_q;
    clk_cnt_d = clk_cnt_q;
    case (state_q)
      sarcs_pkg::SARCS_IDLE: begin
        clk_cnt_d = 4'h0;
        if (start) begin
          // Low-power mode tracks three clocks first, pin mode converts now
          state_d = (tm_lp && !pin_lp) ? sarcs_pkg::SARCS_TRACK
                                       : sarcs_pkg::SARCS_CONVERT;
        end
      end
      sarcs_pkg::SARCS_TRACK: begin
        if (sar_tick) begin
          clk_cnt_d = clk_cnt_q + 4'h1;
        end
        if (track_end) begin
          state_d   = sarcs_pkg::SARCS_CONVERT;
          clk_cnt_d = 4'h0;
        end
      end
      sarcs_pkg::SARCS_CONVERT: begin
        if (sar_tick) begin
          clk_cnt_d = clk_cnt_q + 4'h1;
        end
        if (conv_end) begin
          state_d   = sarcs_pkg::SARCS_IDLE;
          clk_cnt_d = 4'h0;
        end
      end
      default: begin
        state_d   = sarcs_pkg::SARCS_IDLE;
        clk_cnt_d = 4'h0;
      end
    endcase
    if (!adc_on) begin
      state_d   = sarcs_pkg::SARCS_IDLE;
      clk_cnt_d = 4'h0;
    end
  end

  // -------------------------------------------------------------------------
  // Tracking and result
  // -------------------------------------------------------------------------
  // Tracking request
  wire        idle      = (state_q == sarcs_pkg::SARCS_IDLE);
  wire        trk_cont  = !tm_lp && idle;
  wire        trk_lp    = (state_q == sarcs_pkg::SARCS_TRACK) ||
                          (pin_lp && idle && pin_low);
  wire        track_d   = adc_on && !sby_s2_q && (trk_cont || trk_lp);

  // Justified result
  wire        diff_rd   = mux_q[`SARCS_MUX_HVDIFF_BIT];
  wire [5:0]  sext      = diff_rd ? {6{sar_result[9]}} : 6'h00;
  wire [7:0]  hi_d      = lj ? sar_result[9:2] : {sext, sar_result[9:8]};
  wire [7:0]  lo_d      = lj ? {sar_result[1:0], 6'h00} : sar_result[7:0];

  // -------------------------------------------------------------------------
  // Read mux
  // -------------------------------------------------------------------------
  wire [7:0]  ctl_rd    = {ctrl_q[7:6], done_q, busy_q, ctrl_q[3:0]};
  wire [7:0]  hv_rd     = {hv_amp_q[7], 3'h0, hv_amp_q[3:0]};
  logic [7:0] rd_d;

  always_comb begin
    rd_d = 8'h00;
    if (sel_hv) begin
      rd_d = hv_rd;
    end else if (sel_ctl) begin
      rd_d = ctl_rd;
    end else if (sel_cfg) begin
      rd_d = cfg_q;
    end else if (sel_hi) begin
      rd_d = res_hi_q;
    end else if (sel_lo) begin
      rd_d = res_lo_q;
    end else if (sel_mux) begin
      rd_d = {5'h00, mux_q[2:0]};
    end
  end

  // -------------------------------------------------------------------------
  // Synchronisers
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      sby_s1_q <= 1'b0;
      sby_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_convert_start_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      sby_s1_q <= chip_standby;
      sby_s2_q <= sby_s1_q;
    end
  end

  // -------------------------------------------------------------------------
  // Software registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hv_amp_q <= `SARCS_RST_HV_AMP;
      ctrl_q   <= `SARCS_RST_CONV_CTRL;
      cfg_q    <= `SARCS_RST_CONV_CFG;
      mux_q    <= `SARCS_RST_MUX_CFG;
    end else if (wr_en) begin
      if (sel_hv) begin
        hv_amp_q <= {wdata[7], 3'h0, wdata[3:0]};
      end else if (sel_ctl) begin
        ctrl_q <= wdata;
      end else if (sel_cfg) begin
        cfg_q <= wdata;
      end else if (sel_mux) begin
        mux_q <= {5'h00, wdata[2:0]};
      end
    end
  end

  // -------------------------------------------------------------------------
  // Sequencer state
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= sarcs_pkg::SARCS_IDLE;
      clk_cnt_q <= 4'h0;
    end else begin
      state_q   <= state_d;
      clk_cnt_q <= clk_cnt_d;
    end
  end

  // -------------------------------------------------------------------------
  // Busy and done flags
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      // Busy high for the whole conversion
      if (start) begin
        busy_q <= 1'b1;
      end else if (finish || !adc_on) begin
        busy_q <= 1'b0;
      end
      // Done set on conversion finish, not on disable; set beats software clear
      if (finish) begin
        done_q <= 1'b1;
      end else if (wr_ctl && !wdata[`SARCS_CTL_DONE_BIT]) begin
        done_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Result registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
    end else if (finish) begin
      res_hi_q <= hi_d;
      res_lo_q <= lo_d;
    end
  end

  // -------------------------------------------------------------------------
  // Start spacing
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_q <= 16'h0000;
    end else if (start) begin
      rate_cnt_q <= 16'(`SARCS_MIN_SAMPLE_CYC - 1);
    end else if (!rate_ok) begin
      rate_cnt_q <= rate_cnt_q - 16'h0001;
    end
  end

  // -------------------------------------------------------------------------
  // Output flops
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q     <= 1'b0;
      track_q   <= 1'b0;
      convert_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      irq_q     <= finish;
      track_q   <= track_d;
      convert_q <= (state_d == sarcs_pkg::SARCS_CONVERT);
      rdata_q   <= rd_en ? rd_d : 8'h00;
    end
  end

  assign rdata              = rdata_q;
  assign hv_amp_enable      = hv_amp_q[`SARCS_HV_EN_BIT];
  assign hv_amp_gain_select = hv_amp_q[3:0];
  assign hv_ref_to_neg      = mux_q[`SARCS_MUX_HVDIFF_BIT];
  assign conv_enable        = ctrl_q[`SARCS_CTL_EN_BIT];
  assign track_en           = track_q;
  assign convert_en         = convert_q;
  assign conv_irq           = irq_q;

endmodule
`default_nettype wire

/* rtl/sarcs_cfg.svh */
// Constants for the conversion sequencer: offsets, fields, resets, timing
`ifndef SARCS_CFG_SVH
`define SARCS_CFG_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define SARCS_ADDR_W          8
`define SARCS_OFF_HV_AMP      8'hD6
`define SARCS_OFF_CONV_CTRL   8'hE8
`define SARCS_OFF_CONV_CFG    8'hBC
`define SARCS_OFF_RES_HI      8'hBF
`define SARCS_OFF_RES_LO      8'hBE
`define SARCS_OFF_MUX_CFG     8'hBA

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define SARCS_HV_EN_BIT       7
`define SARCS_CTL_EN_BIT      7
`define SARCS_CTL_TM_BIT      6
`define SARCS_CTL_DONE_BIT    5
`define SARCS_CTL_BUSY_BIT    4
`define SARCS_CTL_CM_HI       3
`define SARCS_CTL_CM_LO       2
`define SARCS_CTL_LJ_BIT      0
`define SARCS_CFG_DIV_HI      7
`define SARCS_CFG_DIV_LO      3
`define SARCS_MUX_HVDIFF_BIT  2

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define SARCS_RST_HV_AMP      8'h00
`define SARCS_RST_CONV_CTRL   8'h00
`define SARCS_RST_CONV_CFG    8'hF8
`define SARCS_RST_MUX_CFG     8'h00

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define SARCS_CLK_MHZ         100
`define SARCS_MAX_KSPS        100
`define SARCS_MIN_SAMPLE_CYC  ((`SARCS_CLK_MHZ * 1000 + `SARCS_MAX_KSPS - 1) / `SARCS_MAX_KSPS)
`define SARCS_TRACK_CLKS      4'h3
`define SARCS_CONV_CLKS       4'hB
`define SARCS_RES_W           10

`endif

/* rtl/sarcs_pkg.sv */
// Types for the conversion sequencer
package sarcs_pkg;

  typedef enum logic [1:0] {
    SARCS_SRC_SOFT,
    SARCS_SRC_TMR3,
    SARCS_SRC_PIN,
    SARCS_SRC_TMR2
  } sarcs_src_t;

  typedef enum logic [1:0] {
    SARCS_IDLE,
    SARCS_TRACK,
    SARCS_CONVERT
  } sarcs_state_t;

endpackage

/* rtl/sarcs_clk_div.sv */
// Conversion clock tick generator
`timescale 1ns/1ps
`default_nettype none

module sarcs_clk_div (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Control
  input  wire logic       run,
  input  wire logic [4:0] div,
  // Tick
  output logic            tick
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       tick_q;
  wire        wrap = (cnt_q >= div);

  assign cnt_d = (!run || wrap) ? 5'h00 : cnt_q + 5'h01;
  assign tick  = tick_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= run && wrap;
    end
  end

endmodule
`default_nettype wire

/* bench/sarcs_top_properties.sv */
// Port checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sarcs_props (
  // Clock and register port
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  // Front end
  input wire logic       hv_amp_enable,
  input wire logic [3:0] hv_amp_gain_select,
  input wire logic       hv_ref_to_neg,
  input wire logic       conv_enable,
  input wire logic       convert_en,
  input wire logic       conv_irq
);
  logic [4:0]  div_q;
  logic [11:0] cnt_q;
  // Divider copy and conversion length counter
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) div_q <= 5'h1F;
    else if (wr_en && addr == 8'hBC) div_q <= wdata[7:3];
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) cnt_q <= 12'h000;
    else cnt_q <= convert_en ? cnt_q + 12'h001 : 12'h000;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_amp_enable: assert property (wr_en && addr == 8'hD6 |=> hv_amp_enable == ($past(wdata) >> 7))
    else $error("amplifier enable differs from written bit");
  a_amp_gain: assert property (wr_en && addr == 8'hD6 |=> hv_amp_gain_select == ($past(wdata) & 8'h0F))
    else $error("gain select differs from written code");
  a_ref_route: assert property (wr_en && addr == 8'hBA |=> hv_ref_to_neg == (($past(wdata) >> 2) & 8'h01))
    else $error("reference routing differs from written bit");
  a_reserved_zero: assert property (rd_en && addr == 8'hD6 |=> (rdata & 8'h70) == 8'h00)
    else $error("reserved amplifier bits read nonzero");
  a_busy_read: assert property (rd_en && addr == 8'hE8 && convert_en ##1 convert_en |-> rdata[4])
    else $error("busy bit low during conversion");
  a_irq_single: assert property (conv_irq |=> !conv_irq)
    else $error("completion pulse longer than one cycle");
  a_irq_cause: assert property ($fell(convert_en) && conv_enable |-> ##[0:2] conv_irq)
    else $error("no completion pulse after conversion");
  a_conv_length: assert property ($fell(convert_en) && conv_enable |->
    cnt_q >= 10 * (div_q + 1) && cnt_q <= 12 * (div_q + 1))
    else $error("conversion length off divider setting");
endmodule
bind sarcs_top sarcs_props i_props (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .hv_amp_enable,
  .hv_amp_gain_select, .hv_ref_to_neg, .conv_enable, .convert_en, .conv_irq);
`default_nettype wire

/* bench/sarcs_far_end.sv */
// Far side model: timers, convert-start pin and converter result
`timescale 1ns/1ps
`default_nettype none
module sarcs_far_end (
  // Clock and status
  input  wire logic       clock,
  input  wire logic       convert_en,
  // Start sources and result
  output logic            tmr2_ovf,
  output logic            tmr3_ovf,
  output logic            pin,
  output logic      [9:0] sar_result
);
  logic [9:0] res;
  logic [1:0] hold;
  initial begin
    {tmr2_ovf, tmr3_ovf, sar_result, res, hold} = '0;
    pin = 1'b1;
  end
  // Result valid only around a conversion, scrambled otherwise
  always @(posedge clock) begin
    hold <= convert_en ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
    sar_result <= (convert_en || hold != 2'h0) ? res : ~sar_result;
  end
  task automatic fire(input logic [1:0] src);
    @(posedge clock);
    if (src == 2'h2) begin
      pin <= 1'b0;
      repeat (12) @(posedge clock);
      pin <= 1'b1;
    end else begin
      tmr3_ovf <= (src == 2'h1);
      tmr2_ovf <= (src == 2'h3);
      @(posedge clock);
      tmr3_ovf <= 1'b0;
      tmr2_ovf <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* bench/test_sar_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module test_sar_conversion_sequencer;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        rd_q  = 1'b0;
  logic        trk   = 1'b0;
  logic        sby   = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, ctl, d;
  logic        tmr2_ovf, tmr3_ovf, pin, hv_amp_enable, hv_ref_to_neg, conv_enable, track_en, convert_en, conv_irq;
  logic [3:0]  hv_amp_gain_select;
  logic [9:0]  sar_result, r;
  logic [15:0] v;
  logic [7:0]  q[$];
  int          error_cnt = 0, comparisons = 0, irqs = 0, cyc = 0, n, k, b;
  always #5 clock = ~clock;
  sarcs_top i_dut (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .tmr2_ovf, .tmr3_ovf,
    .ext_convert_start_pin(pin), .chip_standby(sby), .sar_result, .hv_amp_enable, .hv_amp_gain_select,
    .hv_ref_to_neg, .conv_enable, .track_en, .convert_en, .conv_irq);
  sarcs_far_end i_far (.clock, .convert_en, .tmr2_ovf, .tmr3_ovf, .pin, .sar_result);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clock);
    addr <= a;
    wdata <= dv;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    q.push_back(exp);
    @(posedge clock);
    rd_en <= 1'b0;
  endtask
  task automatic go(input logic [1:0] m);
    if (m == 2'h0) wr(8'hE8, ctl | 8'h10);
    else i_far.fire(m);
  endtask
  // Read data watcher, event counters and timeout
  always @(posedge clock) begin
    cyc++;
    if (rd_q) chk(rdata, q.pop_front());
    rd_q <= rd_en;
    if (conv_irq === 1'b1) irqs++;
    if (track_en === 1'b1) trk = 1'b1;
    if (cyc == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(71));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'hD6, 8'h00);
    rd(8'hE8, 8'h00);
    rd(8'hBC, 8'hF8);
    rd(8'h55, 8'h00);
    $display("Test reset values done");
    wr(8'hE8, 8'h80);
    sby <= 1'b1;
    repeat (5) @(negedge clock);
    chk(8'(track_en), 8'h00);
    @(posedge clock);
    sby <= 1'b0;
    repeat (5) @(negedge clock);
    chk(8'(track_en), 8'h01);
    $display("Test standby done");
    for (k = 0; k < 16; k++) begin
      d = {4'($urandom), 4'(k)};
      wr(8'hD6, d);
      @(negedge clock);
      chk(8'(hv_amp_enable), 8'(d[7]));
      chk(8'(hv_amp_gain_select), 8'(k));
      rd(8'hD6, d & 8'h8F);
    end
    $display("Test amplifier control done");
    for (k = 0; k < 8; k++) begin
      ctl = 8'h80 | (8'(k / 4) << 6) | (8'(k % 4) << 2) | 8'(k % 2);
      r = 10'($urandom);
      i_far.res = r;
      wr(8'hBC, 8'(k) << 3);
      wr(8'hBA, 8'(k / 4) << 2);
      wr(8'hE8, ctl);
      repeat (2) @(negedge clock);
      chk(8'(track_en), 8'(k < 4));
      chk(8'(hv_ref_to_neg), 8'(k / 4));
      b = irqs;
      go(2'((k + 1) % 4));
      repeat (30) @(posedge clock);
      chk(8'(irqs), 8'(b));
      @(negedge clock);
      trk = 1'b0;
      go(2'(k % 4));
      for (n = 0; n < 500 && convert_en !== 1'b1; n++) @(posedge clock);
      rd(8'hE8, ctl | 8'h10);
      go(2'(k % 4));
      for (n = 0; n < 500 && irqs == b; n++) @(posedge clock);
      repeat (20) @(posedge clock);
      chk(8'(irqs - b), 8'h01);
      if (k >= 4) chk(8'(trk), 8'h01);
      v = (k % 2) ? {r, 6'h00} : {{6{r[9] & (k >= 4)}}, r};
      rd(8'hE8, ctl | 8'h20);
      rd(8'hBF, v[15:8]);
      rd(8'hBE, v[7:0]);
      wr(8'hE8, ctl);
      rd(8'hE8, ctl);
      repeat (1000) @(posedge clock);
      $display("Test conversion %0d done", k);
    end
    end_sim();
  end
endmodule
`default_nettype wire
